// *** hdl/rf_transparent_frame_codec.sv ***
// Transparent RF frame codec on the front-end side of the link
//
// Notes on behaviour
// RULE_01 - Front-end wraps RF data into link frames and unwraps frames toward RF.
// RULE_02 - RF error-detection bytes pass through untouched; the card module checks them.
// RULE_03 - Command bit 4 selects Type A bit alignment (0) or byte alignment (1).
// RULE_04 - Type A payload: unused bits of the final byte are sent as zero.
// RULE_05 - Type A payload is whole bytes plus one to eight low valid bits.
// RULE_06 - Outgoing admin codes: 0000 none, 1000 Type A notice, 1001 init forward.
// RULE_07 - Front-end never sends a reserved admin code.
// RULE_08 - Incoming admin codes: 0000 none, 0001 go initial, 0010 go halt.
// RULE_09 - Data field is accepted together with any admin code.
// RULE_10 - Admin code and data are decoded by the sending direction.
// RULE_11 - Anticollision and selection happen locally, with no frames exchanged.
// RULE_12 - Card module supplies passive-mode init data; front-end uses it on RF.
// RULE_13 - An RF frame larger than one payload is never carried.
// RULE_14 - Type A bit count comes from payload byte length, per direction.
// RULE_15 - Incoming frame without data field means nothing goes out on RF.
// RULE_16 - Command byte top three bits carry the fixed transport pattern.
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "frame_codec_defines.svh"

module rf_transparent_frame_codec #(
	parameter int MAX_PAYLOAD = `MAX_PAYLOAD,
	parameter int LEN_W = 5,
	parameter int BITS_W = 8
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [7:0] rf_rx_data,
	input wire logic rf_rx_valid,
	input wire logic rf_rx_last,
	input wire logic [3:0] rf_rx_last_bits,
	input wire logic rf_rx_init_fwd,
	output logic rf_rx_ready,
	input wire logic rf_type_a_selected,
	input wire logic rf_anticoll_busy,
	output frame_codec_pkg::link_word_s link_tx_word,
	output logic link_tx_valid,
	input wire logic link_tx_ready,
	input wire frame_codec_pkg::link_word_s link_rx_word,
	input wire logic link_rx_valid,
	output logic [7:0] rf_tx_data,
	output logic rf_tx_valid,
	output logic rf_tx_last,
	output logic rf_tx_byte_aligned,
	output logic [BITS_W-1:0] rf_tx_bits,
	output logic rf_tx_bits_ok,
	output logic rf_tx_bits_valid,
	output logic rf_no_response,
	output logic goto_init,
	output logic goto_halt
);
	import frame_codec_pkg::*;

	logic [1:0] ctrl_ff;
	logic [`ST_W-1:0] status_ff;
	logic [`ST_W-1:0] st_set;
	logic [`ST_W-1:0] st_clr;
	logic [31:0] readdata_ff;
	logic [31:0] rd_mux;
	logic rd_ack_ff;
	logic enabled;
	tx_state_e tx_state_ff;
	logic [7:0] pay_mem [MAX_PAYLOAD];
	logic [LEN_W-1:0] wr_idx_ff;
	logic [LEN_W-1:0] rd_idx_ff;
	logic [LEN_W-1:0] tx_len_ff;
	logic tx_over_ff;
	logic notice_ff;
	admin_t tx_admin_ff;
	admin_t nxt_tx_admin;
	logic tx_aligned_ff;
	logic rx_take;
	logic pay_full;
	logic tx_drop;
	logic frame_done;
	logic [7:0] keep_mask;
	logic [7:0] store_byte;
	link_word_s buf_in;
	logic buf_in_valid;
	logic buf_in_ready;
	logic [BITS_W-1:0] tx_bits;
	logic tx_bits_ok;
	logic rx_in_frame_ff;
	logic rx_skip_ff;
	logic [LEN_W-1:0] rx_cnt_ff;
	admin_t rx_admin_ff;
	logic rx_hdr;
	logic rx_pat_ok;
	logic rx_bits_load_ff;
	logic [7:0] rf_tx_data_ff;
	logic rf_tx_valid_ff;
	logic rf_tx_last_ff;
	logic no_resp_ff;
	logic init_ff;
	logic halt_ff;

	assign enabled = ctrl_ff[`CTRL_ENABLE];

	// ****************************************
	// Register slave
	// ****************************************
	// Reads answer one cycle late so read data come from a flop
	assign avs_waitrequest = avs_read & ~rd_ack_ff;
	assign avs_readdata = readdata_ff;

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			ctrl_ff <= `CTRL_RESET;
		end else if (avs_write && avs_address == `REG_CTRL) begin
			ctrl_ff <= avs_writedata[1:0];
		end
	end

	always_comb begin
		rd_mux = 32'h0;
		unique case (avs_address)
			`REG_CTRL: rd_mux = {30'h0, ctrl_ff};
			`REG_STATUS: rd_mux = {26'h0, status_ff};
			`REG_RXINFO: rd_mux = {16'h0, 8'(rf_tx_bits), 2'h0, rf_tx_bits_ok, rf_tx_byte_aligned, rx_admin_ff};
			`REG_TXINFO: rd_mux = {16'h0, 8'(tx_bits), 2'h0, tx_bits_ok, tx_aligned_ff, tx_admin_ff};
			default: rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			rd_ack_ff <= 1'b0;
			readdata_ff <= 32'h0;
		end else begin
			rd_ack_ff <= avs_read & ~rd_ack_ff;
			if (avs_read && !rd_ack_ff) begin
				readdata_ff <= rd_mux;
			end
		end
	end

	// Sticky status, write one to clear; a new event beats the clear
	assign st_clr = (avs_write && avs_address == `REG_STATUS) ? avs_writedata[`ST_W-1:0] : '0;

	always_comb begin
		st_set = '0;
		st_set[`ST_INIT_REQ] = init_ff;
		st_set[`ST_HALT_REQ] = halt_ff;
		st_set[`ST_RESERVED] = rx_hdr && rx_pat_ok && !(link_rx_word.data[3:0] inside
			{`ADM_NONE, `ADM_REQ_INIT, `ADM_REQ_HALT});
		st_set[`ST_BAD_PATTERN] = rx_hdr && !rx_pat_ok;
		st_set[`ST_TX_DROP] = tx_drop;
		st_set[`ST_RX_LEN_BAD] = rf_tx_bits_valid && !rf_tx_bits_ok;
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			status_ff <= '0;
		end else begin
			status_ff <= (status_ff & ~st_clr) | st_set;
		end
	end

	// ****************************************
	// RF to link: frame composer
	// ****************************************
	// No intake while selection runs locally or a frame is draining
	assign rf_rx_ready = enabled && !rf_anticoll_busy && tx_state_ff == TX_COLLECT; // see RULE_11
	assign rx_take = rf_rx_valid && rf_rx_ready;
	assign pay_full = (wr_idx_ff == LEN_W'(MAX_PAYLOAD));
	assign frame_done = rx_take && rf_rx_last;
	assign tx_drop = frame_done && (tx_over_ff || pay_full); // see RULE_13
	assign keep_mask = 8'(~(9'h1FF << rf_rx_last_bits)); // see RULE_05

	always_comb begin
		store_byte = rf_rx_data; // see RULE_02
		if (rf_rx_last && !ctrl_ff[`CTRL_TX_BYTE_ALIGNED]) begin
			store_byte = rf_rx_data & keep_mask; // see RULE_04
		end
	end

	// Only the three legal codes can ever be chosen here
	always_comb begin
		nxt_tx_admin = `ADM_NONE; // see RULE_07
		if (rf_rx_init_fwd) begin
			nxt_tx_admin = `ADM_INIT_FWD; // see RULE_06
		end else if (notice_ff) begin
			nxt_tx_admin = `ADM_TYPE_A_NOTICE; // see RULE_06
		end
	end

	always_ff @(posedge core_clk) begin
		if (rx_take && !pay_full) begin
			pay_mem[wr_idx_ff] <= store_byte;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			notice_ff <= 1'b0;
		end else if (rf_type_a_selected) begin
			notice_ff <= 1'b1;
		end else if (frame_done && !tx_drop && !rf_rx_init_fwd) begin
			notice_ff <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			tx_state_ff <= TX_COLLECT;
			wr_idx_ff <= '0;
			rd_idx_ff <= '0;
			tx_len_ff <= '0;
			tx_over_ff <= 1'b0;
			tx_admin_ff <= `ADM_NONE;
			tx_aligned_ff <= 1'b0;
		end else begin
			unique case (tx_state_ff)
				TX_COLLECT: begin
					if (frame_done) begin
						wr_idx_ff <= '0;
						tx_over_ff <= 1'b0;
						if (!tx_drop) begin
							tx_state_ff <= TX_HEADER;
							tx_len_ff <= wr_idx_ff + LEN_W'(1);
							tx_admin_ff <= nxt_tx_admin;
							// Selection notice data travel byte aligned
							tx_aligned_ff <= ctrl_ff[`CTRL_TX_BYTE_ALIGNED] ||
								(nxt_tx_admin == `ADM_TYPE_A_NOTICE); // see RULE_03
						end
					end else if (rx_take) begin
						if (pay_full) begin
							tx_over_ff <= 1'b1;
						end else begin
							wr_idx_ff <= wr_idx_ff + LEN_W'(1);
						end
					end
				end
				TX_HEADER: begin
					if (buf_in_ready) begin
						tx_state_ff <= TX_BODY;
						rd_idx_ff <= '0;
					end
				end
				TX_BODY: begin
					if (buf_in_ready) begin
						rd_idx_ff <= rd_idx_ff + LEN_W'(1);
						if (rd_idx_ff == tx_len_ff - LEN_W'(1)) begin
							tx_state_ff <= TX_COLLECT;
						end
					end
				end
			endcase
		end
	end

	always_comb begin
		buf_in_valid = (tx_state_ff != TX_COLLECT);
		buf_in.last = (tx_state_ff == TX_BODY) && (rd_idx_ff == tx_len_ff - LEN_W'(1));
		buf_in.data = pay_mem[rd_idx_ff]; // see RULE_01
		if (tx_state_ff == TX_HEADER) begin
			buf_in.data = {`CMD_PATTERN, tx_aligned_ff, tx_admin_ff}; // see RULE_16
		end
	end

	two_entry_buffer #(
		.W($bits(link_word_s))
	) u_tx_buffer (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.in_data(buf_in),
		.in_valid(buf_in_valid),
		.in_ready(buf_in_ready),
		.out_data(link_tx_word),
		.out_valid(link_tx_valid),
		.out_ready(link_tx_ready)
	);

	typea_bit_count #(
		.LEN_W(LEN_W),
		.BITS_W(BITS_W)
	) u_tx_count (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.len(tx_len_ff),
		.from_card(1'b0),
		.byte_aligned(tx_aligned_ff),
		.load(tx_state_ff == TX_HEADER && buf_in_ready),
		.bits(tx_bits),
		.bits_ok(tx_bits_ok),
		.done()
	);

	// ****************************************
	// Link to RF: frame interpreter
	// ****************************************
	assign rx_hdr = enabled && link_rx_valid && !rx_in_frame_ff;
	assign rx_pat_ok = (link_rx_word.data[7:5] == `CMD_PATTERN); // see RULE_16

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			rx_in_frame_ff <= 1'b0;
			rx_skip_ff <= 1'b0;
			rx_cnt_ff <= '0;
			rx_admin_ff <= `ADM_NONE;
			rf_tx_byte_aligned <= 1'b0;
			rf_tx_data_ff <= 8'h00;
			rf_tx_valid_ff <= 1'b0;
			rf_tx_last_ff <= 1'b0;
			no_resp_ff <= 1'b0;
			init_ff <= 1'b0;
			halt_ff <= 1'b0;
			rx_bits_load_ff <= 1'b0;
		end else begin
			rf_tx_valid_ff <= 1'b0;
			rf_tx_last_ff <= 1'b0;
			no_resp_ff <= 1'b0;
			init_ff <= 1'b0;
			halt_ff <= 1'b0;
			rx_bits_load_ff <= 1'b0;
			if (rx_hdr) begin
				rx_in_frame_ff <= !link_rx_word.last;
				rx_skip_ff <= !rx_pat_ok;
				rx_cnt_ff <= '0;
				if (rx_pat_ok) begin
					// Codes read with card-to-front-end meanings
					rx_admin_ff <= link_rx_word.data[3:0]; // see RULE_10
					rf_tx_byte_aligned <= link_rx_word.data[`CMD_STRUCT_BIT]; // see RULE_03
					init_ff <= (link_rx_word.data[3:0] == `ADM_REQ_INIT); // see RULE_08
					halt_ff <= (link_rx_word.data[3:0] == `ADM_REQ_HALT); // see RULE_08
					no_resp_ff <= link_rx_word.last; // see RULE_15
					rx_bits_load_ff <= link_rx_word.last;
				end
			end else if (enabled && link_rx_valid) begin
				rx_in_frame_ff <= !link_rx_word.last;
				if (!rx_skip_ff) begin
					// Data go out whatever the admin code, init data included
					rf_tx_data_ff <= link_rx_word.data; // see RULE_09, see RULE_12
					rf_tx_valid_ff <= 1'b1;
					rf_tx_last_ff <= link_rx_word.last;
					rx_bits_load_ff <= link_rx_word.last;
					if (rx_cnt_ff != '1) begin
						rx_cnt_ff <= rx_cnt_ff + LEN_W'(1);
					end
				end
			end
		end
	end

	assign rf_tx_data = rf_tx_data_ff;
	assign rf_tx_valid = rf_tx_valid_ff;
	assign rf_tx_last = rf_tx_last_ff;
	assign rf_no_response = no_resp_ff;
	assign goto_init = init_ff;
	assign goto_halt = halt_ff;

	typea_bit_count #(
		.LEN_W(LEN_W),
		.BITS_W(BITS_W)
	) u_rx_count (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.len(rx_cnt_ff),
		.from_card(1'b1),
		.byte_aligned(rf_tx_byte_aligned),
		.load(rx_bits_load_ff),
		.bits(rf_tx_bits),
		.bits_ok(rf_tx_bits_ok),
		.done(rf_tx_bits_valid)
	);

	// ****************************************
	// Checks
	// ****************************************
	a_header_pattern: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE_16
		tx_state_ff == TX_HEADER |-> buf_in.data[7:5] == 3'h2 && !buf_in.last)
		else $error("header lacks transport pattern");

	a_admin_legal: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE_07
		tx_state_ff == TX_HEADER |-> buf_in.data[3:0] inside {4'h0, 4'h8, 4'h9})
		else $error("reserved admin code sent");

	a_struct_follows: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE_03
		frame_done && !tx_drop && !notice_ff && !rf_rx_init_fwd |=>
		tx_state_ff == TX_HEADER && buf_in.data[4] == $past(ctrl_ff[1]))
		else $error("structure bit does not follow control");

	a_oversize_dropped: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE_13
		tx_drop |=> tx_state_ff == TX_COLLECT && status_ff[4] && wr_idx_ff == '0)
		else $error("oversize frame not dropped");

	a_quiet_selection: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE_11
		rf_anticoll_busy |=> $stable(wr_idx_ff) && !$rose(tx_state_ff == TX_HEADER))
		else $error("frame composed during selection");

	a_init_request: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE_08
		rx_hdr && link_rx_word.data == 8'h41 |=> goto_init && !goto_halt ##1 status_ff[0])
		else $error("go-initial request not raised");

	a_empty_frame_silent: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE_15
		rx_hdr && rx_pat_ok && link_rx_word.last |=> rf_no_response && !rf_tx_valid ##1 !rf_tx_valid)
		else $error("RF output on frame without data");

	a_typea_padding: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE_04
		rx_take && rf_rx_last && !ctrl_ff[1] && rf_rx_last_bits == 4'h3 && !pay_full |=>
		pay_mem[$past(wr_idx_ff)][7:3] == 5'h00)
		else $error("type A padding not zero");

endmodule // rf_transparent_frame_codec

`default_nettype wire

// *** hdl/frame_codec_defines.svh ***
// Constants for the transparent RF frame codec
`ifndef FRAME_CODEC_DEFINES_SVH
`define FRAME_CODEC_DEFINES_SVH

// ****************************************
// Command byte layout and admin codes
// ****************************************
`define CMD_PATTERN 3'h2
`define CMD_STRUCT_BIT 4
`define ADM_NONE 4'h0
`define ADM_TYPE_A_NOTICE 4'h8
`define ADM_INIT_FWD 4'h9
`define ADM_REQ_INIT 4'h1
`define ADM_REQ_HALT 4'h2

// ****************************************
// Payload sizing
// ****************************************
`define MAX_PAYLOAD 29
`define BITS_PER_BYTE 8
`define TYPEA_BITS_PER_BYTE 9
`define FE_ONE_BYTE_BITS 7
`define CM_ONE_BYTE_BITS 4

// ****************************************
// Register map and fields
// ****************************************
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_RXINFO 4'h8
`define REG_TXINFO 4'hC
`define CTRL_ENABLE 0
`define CTRL_TX_BYTE_ALIGNED 1
`define CTRL_RESET 2'h1
`define ST_INIT_REQ 0
`define ST_HALT_REQ 1
`define ST_RESERVED 2
`define ST_BAD_PATTERN 3
`define ST_TX_DROP 4
`define ST_RX_LEN_BAD 5
`define ST_W 6

`endif

// *** hdl/frame_codec_pkg.sv ***
// Types shared by the transparent RF frame codec
package frame_codec_pkg;

	typedef struct packed {
		logic last;
		logic [7:0] data;
	} link_word_s;

	typedef enum {TX_COLLECT, TX_HEADER, TX_BODY} tx_state_e;

	typedef logic [3:0] admin_t;

endpackage

// *** hdl/two_entry_buffer.sv ***
// Two-entry valid/ready buffer for link words
`timescale 1ns/10ps
`default_nettype none

module two_entry_buffer #(
	parameter int W = 9
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [W-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [W-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);

	logic [W-1:0] slot_ff [2];
	logic [1:0] cnt_ff;
	logic push;
	logic pop;

	assign in_ready = (cnt_ff != 2'h2);
	assign out_valid = (cnt_ff != 2'h0);
	assign out_data = slot_ff[0];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// ****************************************
	// Storage
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (pop) begin
			slot_ff[0] <= (cnt_ff == 2'h2) ? slot_ff[1] : in_data;
			slot_ff[1] <= in_data;
		end else if (push) begin
			if (cnt_ff == 2'h0) begin
				slot_ff[0] <= in_data;
			end else begin
				slot_ff[1] <= in_data;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			cnt_ff <= 2'h0;
		end else begin
			cnt_ff <= cnt_ff + 2'(push) - 2'(pop);
		end
	end

	a_stall_holds_word: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE_01
		out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("buffered word changed during stall");

	a_count_in_range: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE_01
		cnt_ff == 2'h2 |-> !in_ready ##1 cnt_ff != 2'h3)
		else $error("buffer count out of range");

endmodule // two_entry_buffer

`default_nettype wire

// *** hdl/typea_bit_count.sv ***
// Payload length to RF bit count, per direction and structure
`timescale 1ns/10ps
`default_nettype none
`include "frame_codec_defines.svh"

module typea_bit_count #(
	parameter int LEN_W = 5,
	parameter int BITS_W = 8
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [LEN_W-1:0] len,
	input wire logic from_card,
	input wire logic byte_aligned,
	input wire logic load,
	output logic [BITS_W-1:0] bits,
	output logic bits_ok,
	output logic done
);

	logic [BITS_W-1:0] nxt_bits;
	logic nxt_ok;

	// Nine RF bits per data byte, so some lengths have no valid count
	always_comb begin
		int k;
		k = (int'(len) * `BITS_PER_BYTE) / `TYPEA_BITS_PER_BYTE;
		nxt_bits = BITS_W'(k * `TYPEA_BITS_PER_BYTE); // see RULE_14
		nxt_ok = ((k * `TYPEA_BITS_PER_BYTE + 7) / `BITS_PER_BYTE) == int'(len);
		if (byte_aligned) begin
			nxt_bits = BITS_W'(int'(len) * `BITS_PER_BYTE);
			nxt_ok = 1'b1;
		end else if (len == LEN_W'(1)) begin
			nxt_bits = from_card ? BITS_W'(`CM_ONE_BYTE_BITS) : BITS_W'(`FE_ONE_BYTE_BITS); // see RULE_10
			nxt_ok = 1'b1;
		end else if (len == LEN_W'(0)) begin
			nxt_bits = '0;
			nxt_ok = from_card; // see RULE_15
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			bits <= '0;
			bits_ok <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= load;
			if (load) begin
				bits <= nxt_bits;
				bits_ok <= nxt_ok;
			end
		end
	end

	a_one_byte_count: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE_14
		load && len == LEN_W'(1) && !byte_aligned |=>
		done && bits_ok && bits == (from_card ? BITS_W'(4) : BITS_W'(7)))
		else $error("one-byte payload bit count wrong");

	a_nine_bit_pairs: assert property (@(posedge core_clk) disable iff (!reset_n) // see RULE_05
		load && !byte_aligned && (len == LEN_W'(2) || len == LEN_W'(10)) |=>
		(bits == BITS_W'(9) && bits_ok) || (bits == BITS_W'(72) && !bits_ok))
		else $error("type A bit count mapping wrong");

endmodule // typea_bit_count

`default_nettype wire

// *** testbench/card_module_model.sv ***
// Card module model on the far side of the link
`timescale 1ns/10ps
`default_nettype none

module card_module_model (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire frame_codec_pkg::link_word_s link_tx_word,
	input wire logic link_tx_valid,
	output logic link_tx_ready,
	output frame_codec_pkg::link_word_s link_rx_word,
	output logic link_rx_valid
);
	import frame_codec_pkg::*;
	link_word_s got_q[$];
	logic [1:0] stall_ff;
	initial begin
		link_rx_word = '0;
		link_rx_valid = 1'b0;
	end
	// Stall one cycle in four, so the buffer must hold words
	always @(posedge core_clk) begin
		stall_ff <= reset_n ? stall_ff + 2'h1 : 2'h0;
		if (link_tx_valid === 1'b1 && link_tx_ready === 1'b1) begin
			got_q.push_back(link_tx_word);
		end
	end
	assign link_tx_ready = stall_ff != 2'h2;
	// Header, then n bytes counting down; called just after an edge
	task automatic send_frame(input logic [2:0] pat, input logic al, input admin_t adm, input int n,
		input logic [7:0] st);
		link_rx_valid <= 1'b1;
		link_rx_word <= '{last: n == 0, data: {pat, al, adm}};
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk);
			link_rx_word <= '{last: i == n - 1, data: st - i[7:0]};
		end
		@(posedge core_clk);
		link_rx_valid <= 1'b0;
		// Released line must not keep showing the last word
		link_rx_word <= ~link_rx_word;
	endtask
endmodule // card_module_model

`default_nettype wire

// *** testbench/rf_transparent_frame_codec_tb_top.sv ***
// Self-checking bench for the transparent RF frame codec
`timescale 1ns/10ps
`default_nettype none
`include "frame_codec_defines.svh"

module rf_transparent_frame_codec_tb_top;
	import frame_codec_pkg::*;
	logic core_clk, reset_n, avs_read, avs_write, avs_waitrequest, rf_rx_valid, rf_rx_last, rf_rx_init_fwd;
	logic rf_rx_ready, rf_type_a_selected, rf_anticoll_busy, link_tx_valid, link_tx_ready, link_rx_valid;
	logic rf_tx_valid, rf_tx_last, rf_tx_byte_aligned, rf_tx_bits_ok, rf_tx_bits_valid, rf_no_response;
	logic goto_init, goto_halt;
	logic [3:0] avs_address, rf_rx_last_bits;
	logic [31:0] avs_writedata, avs_readdata, d;
	logic [7:0] rf_rx_data, rf_tx_data, rf_tx_bits, last_tx;
	logic [8:0] bits_seen;
	link_word_s link_tx_word, link_rx_word;
	int n_fail, total_checks, n_tx, n_init, n_halt, n_nr, n_last;

	rf_transparent_frame_codec dut_u (.core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .rf_rx_data(rf_rx_data), .rf_rx_valid(rf_rx_valid),
		.rf_rx_last(rf_rx_last), .rf_rx_last_bits(rf_rx_last_bits), .rf_rx_init_fwd(rf_rx_init_fwd),
		.rf_rx_ready(rf_rx_ready), .rf_type_a_selected(rf_type_a_selected), .rf_anticoll_busy(rf_anticoll_busy),
		.link_tx_word(link_tx_word), .link_tx_valid(link_tx_valid), .link_tx_ready(link_tx_ready),
		.link_rx_word(link_rx_word), .link_rx_valid(link_rx_valid), .rf_tx_data(rf_tx_data),
		.rf_tx_valid(rf_tx_valid), .rf_tx_last(rf_tx_last), .rf_tx_byte_aligned(rf_tx_byte_aligned),
		.rf_tx_bits(rf_tx_bits), .rf_tx_bits_ok(rf_tx_bits_ok), .rf_tx_bits_valid(rf_tx_bits_valid),
		.rf_no_response(rf_no_response), .goto_init(goto_init), .goto_halt(goto_halt));
	card_module_model model_u (.core_clk(core_clk), .reset_n(reset_n), .link_tx_word(link_tx_word),
		.link_tx_valid(link_tx_valid), .link_tx_ready(link_tx_ready), .link_rx_word(link_rx_word),
		.link_rx_valid(link_rx_valid));

	// ****************************************
	// Clock, monitor and shared tasks
	// ****************************************
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (rf_tx_valid === 1'b1) begin
			n_tx++;
			last_tx = rf_tx_data;
		end
		if (rf_tx_bits_valid === 1'b1) bits_seen = {rf_tx_bits_ok, rf_tx_bits};
		if (goto_init === 1'b1) n_init++;
		if (goto_halt === 1'b1) n_halt++;
		if (rf_no_response === 1'b1) n_nr++;
		if (rf_tx_last === 1'b1) n_last++;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] wd, output logic [31:0] rd);
		int k;
		@(posedge core_clk);
		k = 0;
		avs_address <= addr;
		avs_writedata <= wd;
		avs_read <= !wr;
		avs_write <= wr;
		do begin
			@(posedge core_clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 100);
		if (avs_waitrequest !== 1'b0) begin
			n_fail++;
			$display("FAIL at %0t: bus request not answered", $time);
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rf_frame(input int n, input logic [7:0] st, input logic [3:0] lb, input logic fwd);
		int k;
		@(posedge core_clk);
		for (int i = 0; i < n; i++) begin
			rf_rx_valid <= 1'b1;
			rf_rx_data <= st - i[7:0];
			rf_rx_last <= i == n - 1;
			rf_rx_last_bits <= lb;
			rf_rx_init_fwd <= fwd;
			k = 0;
			do begin
				@(posedge core_clk);
				k++;
			end while (rf_rx_ready !== 1'b1 && k < 200);
			if (rf_rx_ready !== 1'b1) begin
				n_fail++;
				$display("FAIL at %0t: RF byte never taken", $time);
			end
		end
		rf_rx_valid <= 1'b0;
	endtask
	task automatic expect_link(input logic [7:0] hdr, input int n, input logic [7:0] st, input logic [7:0] mask);
		int k;
		k = 0;
		while (model_u.got_q.size() < n + 1 && k < 300) begin
			@(posedge core_clk);
			k++;
		end
		check(model_u.got_q.size(), n + 1);
		check(model_u.got_q[0], {1'b0, hdr});
		for (int i = 1; i <= n; i++) begin
			check(model_u.got_q[i], {i == n, (st - i[7:0] + 8'h01) & (i == n ? mask : 8'hFF)});
		end
		model_u.got_q.delete();
	endtask
	task automatic link_frame(input logic [2:0] pat, input logic al, input admin_t adm, input int n,
		input logic [7:0] st);
		n_tx = 0;
		n_init = 0;
		n_halt = 0;
		n_nr = 0;
		n_last = 0;
		@(posedge core_clk);
		model_u.send_frame(pat, al, adm, n, st);
		repeat (4) @(posedge core_clk);
	endtask
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		reset_n = 1'b0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		rf_rx_data = 8'h0;
		rf_rx_valid = 1'b0;
		rf_rx_last = 1'b0;
		rf_rx_last_bits = 4'h0;
		rf_rx_init_fwd = 1'b0;
		rf_type_a_selected = 1'b0;
		rf_anticoll_busy = 1'b0;
		repeat (3) @(posedge core_clk);
		reset_n <= 1'b1;
		bus(0, `REG_CTRL, 32'h0, d);
		check(d, 32'h1);
		bus(1, 4'h6, 32'hFFFF_FFFF, d);
		bus(0, 4'h6, 32'h0, d);
		check(d, 32'h0);
		bus(0, `REG_CTRL, 32'h0, d);
		check(d, 32'h1);
		rf_frame(2, 8'hF5, 4'h3, 1'b0);
		expect_link(8'h40, 2, 8'hF5, 8'h07);
		rf_frame(1, 8'hC3, 4'h8, 1'b0);
		expect_link(8'h40, 1, 8'hC3, 8'hFF);
		bus(1, `REG_CTRL, 32'h3, d);
		rf_frame(3, 8'h9A, 4'h1, 1'b1);
		expect_link(8'h59, 3, 8'h9A, 8'hFF);
		rf_anticoll_busy <= 1'b1;
		repeat (2) @(posedge core_clk);
		check(rf_rx_ready, 1'b0);
		rf_anticoll_busy <= 1'b0;
		rf_type_a_selected <= 1'b1;
		@(posedge core_clk);
		rf_type_a_selected <= 1'b0;
		rf_frame(1, 8'h26, 4'h8, 1'b0);
		expect_link(8'h58, 1, 8'h26, 8'hFF);
		link_frame(3'h2, 1'b0, `ADM_REQ_INIT, 1, 8'hAB);
		check(n_init, 32'd1);
		check(n_tx, 32'd1);
		check(last_tx, 8'hAB);
		check(bits_seen, {1'b1, 8'd4});
		link_frame(3'h2, 1'b0, `ADM_REQ_HALT, 2, 8'h5C);
		check(n_halt, 32'd1);
		check(n_tx, 32'd2);
		check(last_tx, 8'h5B);
		check(n_last, 32'd1);
		check(bits_seen, {1'b1, 8'd9});
		bus(0, `REG_STATUS, 32'h0, d);
		check(d[1:0], 2'h3);
		bus(1, `REG_STATUS, 32'h3F, d);
		link_frame(3'h2, 1'b1, `ADM_NONE, 0, 8'h00);
		check(n_nr, 32'd1);
		check(n_tx, 32'd0);
		link_frame(3'h2, 1'b1, 4'h3, 1, 8'h11);
		check(n_tx, 32'd1);
		check(last_tx, 8'h11);
		link_frame(3'h7, 1'b1, `ADM_NONE, 1, 8'h22);
		check(n_tx, 0);
		bus(0, `REG_STATUS, 32'h0, d);
		check(d[3:2], 2'h3);
		bus(0, `REG_RXINFO, 32'h0, d);
		check(d, 32'h0000_0833);
		bus(1, `REG_STATUS, 32'h3F, d);
		link_frame(3'h2, 1'b0, `ADM_NONE, 10, 8'h70);
		check(bits_seen[8], 1'b0);
		bus(1, `REG_CTRL, 32'h1, d);
		rf_frame(30, 8'h80, 4'h8, 1'b0);
		repeat (40) @(posedge core_clk);
		check(model_u.got_q.size(), 0);
		bus(0, `REG_STATUS, 32'h0, d);
		check(d[5:4], 2'h3);
		bus(0, `REG_TXINFO, 32'h0, d);
		check(d, 32'h0000_0838);
		complete_run();
	end
	initial begin
		#(50 * 20000);
		n_fail++;
		$display("FAIL at %0t: watchdog expired", $time);
		complete_run();
	end
endmodule // rf_transparent_frame_codec_tb_top

`default_nettype wire
